/* core/tss_pkg.sv */
package tss_pkg;
    localparam int TSS_MAX_STREAMS   = 255;
    localparam int TSS_MAX_QUEUES    = 15;
    localparam int TSS_MAX_QSTREAMS  = 4096;
    localparam int TSS_MAX_FLOW_PKTS = 15872;
    localparam int TSS_CNT_W         = 24;
    localparam int TSS_REF_GAP_BYTES = 12;
    localparam int TSS_PCT_FULL      = 100;
    localparam int TSS_RATE_W        = 16;
    localparam logic [15:0] TSS_RATE_FULL = 16'hffff;
    localparam logic [1:0] TSS_MODE_SEQ   = 2'h0;
    localparam logic [1:0] TSS_MODE_FLOW  = 2'h1;
    localparam logic [1:0] TSS_MODE_ILV   = 2'h2;
    localparam logic [1:0] TSS_PORT_ETH   = 2'h0;
    localparam logic [1:0] TSS_PORT_POS   = 2'h1;
    localparam logic [1:0] TSS_PORT_ATM   = 2'h2;
    typedef enum logic [2:0] {
        TSS_IDLE, TSS_LOAD, TSS_SEND, TSS_GAP, TSS_NEXT
    } tss_state_t;
endpackage : tss_pkg

/* core/tss_scheduler.sv */
`timescale 1ns/10ps
module tss_scheduler import tss_pkg::*; #(
    parameter int N_STREAMS = 16,
    parameter int SID_W     = 8,
    parameter int CNT_W     = TSS_CNT_W,
    parameter int GAP_W     = 16
) (
    input  wire logic              I_SYS_CLK,
    input  wire logic              I_RST_N,
    input  wire logic              I_START,
    input  wire logic              I_STOP,
    input  wire logic [1:0]        I_MODE,
    input  wire logic [1:0]        I_PORT_KIND,
    input  wire logic [SID_W-1:0]  I_NUM_STREAMS,
    input  wire logic              I_REPEAT_FOREVER,
    input  wire logic [CNT_W-1:0]  I_REPEAT_COUNT,
    input  wire logic [CNT_W-1:0]  I_BURSTS,
    input  wire logic [CNT_W-1:0]  I_PKTS,
    input  wire logic [GAP_W-1:0]  I_STREAM_SPACING,
    input  wire logic [GAP_W-1:0]  I_BURST_SPACING,
    input  wire logic [GAP_W-1:0]  I_PACKET_SPACING,
    input  wire logic [TSS_RATE_W-1:0] I_RATE [N_STREAMS],
    input  wire logic              I_FRAME_SLOT,
    input  wire logic              I_READY,
    output logic                   O_VALID,
    output logic [SID_W-1:0]       O_STREAM_ID,
    output logic                   O_EMPTY_FRAME,
    output logic                   O_LAST,
    output logic                   O_BUSY,
    output logic                   O_IDLE
);
    tss_state_t                state;
    logic [SID_W-1:0]          sid;
    logic [CNT_W-1:0]          bcnt;
    logic [CNT_W-1:0]          pcnt;
    logic [CNT_W-1:0]          rcnt;
    logic [GAP_W-1:0]          gcnt;
    logic [TSS_RATE_W+1:0]     acc [N_STREAMS];
    logic [SID_W-1:0]          isel;
    logic                      ihit;
    logic                      stopped;

    // two-entry skid buffer toward the receiver
    logic [SID_W+1:0]          buf_d [2];
    logic [1:0]                buf_v;
    logic                      in_v;
    logic [SID_W+1:0]          in_d;
    wire                       in_rdy = ~buf_v[1];
    wire                       push   = in_v & in_rdy;
    wire                       pop    = buf_v[0] & I_READY;

    wire is_atm   = (I_PORT_KIND == TSS_PORT_ATM);
    wire is_ilv   = (I_MODE == TSS_MODE_ILV);
    wire is_flow  = (I_MODE == TSS_MODE_FLOW);
    wire last_pkt = (pcnt == I_PKTS - 1'b1);
    wire last_bst = (bcnt == I_BURSTS - 1'b1);
    wire last_str = (sid == I_NUM_STREAMS - 1'b1);
    wire rep_more = I_REPEAT_FOREVER & ~is_flow
                  | (rcnt != '0);
    wire slot_ok  = (I_PORT_KIND == TSS_PORT_ETH) | I_FRAME_SLOT;
    wire [GAP_W-1:0] gap_sel =
        is_atm ? '0 :
        (last_pkt & last_bst) ? I_STREAM_SPACING :
        last_pkt ? I_BURST_SPACING : I_PACKET_SPACING;

    // weighted share arbiter: credit grows by rate, pick first with credit
    always_comb begin
        isel = '0;
        ihit = 1'b0;
        for (int i = N_STREAMS - 1; i >= 0; i--) begin
            if (i < I_NUM_STREAMS && acc[i][TSS_RATE_W]) begin
                isel = SID_W'(i);
                ihit = 1'b1;
            end
        end
    end

    always_comb begin
        in_v = 1'b0;
        in_d = '0;
        if (state == TSS_SEND && slot_ok) begin
            in_v = 1'b1;
            if (is_ilv)
                in_d = {~ihit, 1'b0, isel};
            else
                in_d = {1'b0, last_pkt & last_bst & last_str, sid};
        end else if (state == TSS_GAP && slot_ok && gcnt != '0
                     && I_PORT_KIND != TSS_PORT_ETH) begin
            in_v = 1'b1;
            in_d = {1'b1, 1'b0, sid};
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            for (int i = 0; i < N_STREAMS; i++)
                acc[i] <= '0;
        end else if (state == TSS_SEND && is_ilv && push) begin
            for (int i = 0; i < N_STREAMS; i++) begin
                if (ihit && SID_W'(i) == isel)
                    acc[i] <= acc[i] + {2'b0, I_RATE[i]}
                              - {2'b01, TSS_RATE_W'(0)};
                else if (!acc[i][TSS_RATE_W])
                    acc[i] <= acc[i] + {2'b0, I_RATE[i]};
            end
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            state   <= TSS_IDLE;
            sid     <= '0;
            bcnt    <= '0;
            pcnt    <= '0;
            rcnt    <= '0;
            gcnt    <= '0;
            stopped <= 1'b1;
        end else if (I_STOP) begin
            state   <= TSS_IDLE;
            stopped <= 1'b1;
        end else begin
            case (state)
                TSS_IDLE: if (I_START) begin
                    sid     <= '0;
                    rcnt    <= I_REPEAT_COUNT;
                    stopped <= 1'b0;
                    state   <= TSS_LOAD;
                end
                TSS_LOAD: begin
                    bcnt  <= '0;
                    pcnt  <= '0;
                    state <= TSS_SEND;
                end
                TSS_SEND: if (push) begin
                    if (is_ilv) begin
                        state <= TSS_SEND;
                    end else begin
                        gcnt  <= gap_sel;
                        state <= TSS_GAP;
                        if (!last_pkt) begin
                            pcnt <= pcnt + 1'b1;
                        end else begin
                            pcnt <= '0;
                            bcnt <= bcnt + 1'b1;
                        end
                    end
                end
                TSS_GAP: begin
                    if (gcnt != '0) begin
                        if (I_PORT_KIND == TSS_PORT_ETH || push)
                            gcnt <= gcnt - 1'b1;
                    end else if (pcnt == '0 && bcnt == I_BURSTS) begin
                        state <= TSS_NEXT;
                    end else begin
                        state <= TSS_SEND;
                    end
                end
                TSS_NEXT: begin
                    if (!last_str) begin
                        sid   <= sid + 1'b1;
                        state <= TSS_LOAD;
                    end else if (rep_more) begin
                        if (rcnt != '0)
                            rcnt <= rcnt - 1'b1;
                        sid   <= '0;
                        state <= TSS_LOAD;
                    end else begin
                        stopped <= 1'b1;
                        state   <= TSS_IDLE;
                    end
                end
                default: state <= TSS_IDLE;
            endcase
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N) begin
            buf_v    <= '0;
            buf_d[0] <= '0;
            buf_d[1] <= '0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (buf_v[0]) begin
                        buf_d[1] <= in_d;
                        buf_v[1] <= 1'b1;
                    end else begin
                        buf_d[0] <= in_d;
                        buf_v[0] <= 1'b1;
                    end
                end
                2'b01: begin
                    buf_d[0] <= buf_d[1];
                    buf_v    <= {1'b0, buf_v[1]};
                end
                2'b11: begin
                    if (buf_v[1]) begin
                        buf_d[0] <= buf_d[1];
                        buf_d[1] <= in_d;
                    end else begin
                        buf_d[0] <= in_d;
                    end
                end
                default: buf_v <= buf_v;
            endcase
        end
    end

    assign O_VALID       = buf_v[0];
    assign O_STREAM_ID   = buf_d[0][SID_W-1:0];
    assign O_LAST        = buf_d[0][SID_W];
    assign O_EMPTY_FRAME = buf_d[0][SID_W+1];
    assign O_BUSY        = ~stopped | buf_v[0];
    assign O_IDLE        = stopped & ~buf_v[0];
endmodule : tss_scheduler

/* dv/tb.sv */
`timescale 1ns/10ps
module tb import tss_pkg::*;;
    localparam int NS = 4;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        start = 1'b0;
    logic        stop = 1'b0;
    logic        fev = 1'b0;
    logic        slow = 1'b0;
    logic [1:0]  mode = TSS_MODE_SEQ;
    logic [1:0]  port = TSS_PORT_ETH;
    logic        clr = 1'b0;
    int          empties = 0;
    logic [7:0]  nstr = 8'h01;
    logic [23:0] rep = 24'h0;
    logic [23:0] bur = 24'h1;
    logic [23:0] pkt = 24'h1;
    logic [15:0] rate [NS] = '{default: 16'h4000};
    logic        ready, slot, valid, empty, last, busy, idle;
    logic [7:0]  sid;
    logic [3:0]  seen = 4'h0;
    int          err_total = 0;
    int          num_checks = 0;
    int          words = 0;
    int          cyc = 0;
    always #20 clk = ~clk;
    tss_rx_model rx (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow),
        .o_ready(ready), .o_slot(slot));
    tss_scheduler #(.N_STREAMS(NS)) dut (.I_SYS_CLK(clk), .I_RST_N(rst_n),
        .I_START(start), .I_STOP(stop), .I_MODE(mode),
        .I_PORT_KIND(port), .I_NUM_STREAMS(nstr),
        .I_REPEAT_FOREVER(fev), .I_REPEAT_COUNT(rep), .I_BURSTS(bur),
        .I_PKTS(pkt), .I_STREAM_SPACING(16'h3), .I_BURST_SPACING(16'h2),
        .I_PACKET_SPACING(16'h1), .I_RATE(rate), .I_FRAME_SLOT(slot),
        .I_READY(ready), .O_VALID(valid),
        .O_STREAM_ID(sid), .O_EMPTY_FRAME(empty), .O_LAST(last),
        .O_BUSY(busy), .O_IDLE(idle));
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (clr) begin
            words <= 0;
            empties <= 0;
            seen <= 4'h0;
        end else if (valid && ready && empty) begin
            empties <= empties + 1;
        end else if (valid && ready) begin
            words <= words + 1;
            seen[sid[1:0]] <= 1'b1;
        end
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
        end
    endtask : chk
    task automatic go;
        @(posedge clk) start <= 1'b1;
        clr <= 1'b1;
        @(posedge clk) start <= 1'b0;
        clr <= 1'b0;
        @(negedge clk);
        for (int k = 0; k < 3000 && idle !== 1'b1; k++) @(negedge clk);
    endtask : go
    task automatic t_seq;
        @(posedge clk) nstr <= 8'h03;
        bur <= 24'h2;
        pkt <= 24'h2;
        go();
        chk("seq words", 32'hc, words);
        chk("seq streams", 32'h7, seen);
        chk("seq idle", 32'h1, idle);
    endtask : t_seq
    task automatic t_rep;
        @(posedge clk) nstr <= 8'h02;
        bur <= 24'h1;
        pkt <= 24'h3;
        rep <= 24'h2;
        slow <= 1'b1;
        go();
        chk("repeat words", 32'h12, words);
    endtask : t_rep
    task automatic t_flow;
        @(posedge clk) mode <= TSS_MODE_FLOW;
        fev <= 1'b1;
        rep <= 24'h1;
        pkt <= 24'h2;
        go();
        chk("flow words", 32'h8, words);
        chk("flow idle", 32'h1, idle);
    endtask : t_flow
    task automatic t_pos;
        @(posedge clk) mode <= TSS_MODE_SEQ;
        port <= TSS_PORT_POS;
        nstr <= 8'h01;
        pkt <= 24'h2;
        rep <= 24'h0;
        fev <= 1'b0;
        slow <= 1'b0;
        go();
        chk("pos words", 32'h2, words);
        chk("pos empty frames", 32'h4, empties);
        @(posedge clk) port <= TSS_PORT_ATM;
        go();
        chk("atm words", 32'h2, words);
        chk("atm empty frames", 32'h0, empties);
    endtask : t_pos
    task automatic t_ilv;
        @(posedge clk) mode <= TSS_MODE_ILV;
        port <= TSS_PORT_ETH;
        nstr <= 8'h04;
        fev <= 1'b0;
        rep <= 24'h0;
        slow <= 1'b0;
        go();
        chk("ilv streams", 32'hf, seen);
        chk("ilv busy", 32'h0, idle);
        @(posedge clk) stop <= 1'b1;
        @(posedge clk) stop <= 1'b0;
        repeat (10) @(negedge clk);
        chk("stop idle", 32'h1, idle);
    endtask : t_ilv
    task automatic report_and_stop;
        if (err_total == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_seq();
        t_rep();
        t_flow();
        t_pos();
        t_ilv();
        report_and_stop();
    end
endmodule : tb

/* dv/tss_rx_model.sv */
`timescale 1ns/10ps
module tss_rx_model (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_slow,
    output logic      o_ready,
    output logic      o_slot
);
    logic [1:0] ph;
    always_ff @(posedge i_clk) begin
        ph <= i_rst_n ? ph + 2'h1 : 2'h0;
    end
    // slow receiver stalls half the time
    assign o_ready = !i_slow || ph[1];
    assign o_slot  = !i_slow || ph[0];
endmodule : tss_rx_model

/* dv/tss_scheduler_sva.sv */
`timescale 1ns/10ps
module tss_chk import tss_pkg::*; #(
    parameter int SID_W = 8,
    parameter int CNT_W = 24
) (
    input wire logic             I_SYS_CLK,
    input wire logic             I_RST_N,
    input wire logic             I_START,
    input wire logic             I_STOP,
    input wire logic [1:0]       I_MODE,
    input wire logic [1:0]       I_PORT_KIND,
    input wire logic [SID_W-1:0] I_NUM_STREAMS,
    input wire logic             I_REPEAT_FOREVER,
    input wire logic [CNT_W-1:0] I_REPEAT_COUNT,
    input wire logic             I_READY,
    input wire logic             O_VALID,
    input wire logic [SID_W-1:0] O_STREAM_ID,
    input wire logic             O_EMPTY_FRAME,
    input wire logic             O_LAST,
    input wire logic             O_BUSY,
    input wire logic             O_IDLE
);
    localparam int LAST_WAIT = 300;
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_N);
    logic             take;
    logic             seen;
    logic [SID_W-1:0] prev;
    assign take = O_VALID && I_READY && !O_EMPTY_FRAME;
    always_ff @(posedge I_SYS_CLK) begin
        if (!I_RST_N || O_IDLE) begin
            seen <= 1'b0;
        end else if (take) begin
            seen <= 1'b1;
            prev <= O_STREAM_ID;
        end
    end
    sequence s_launch;
        I_START && O_IDLE && !I_STOP;
    endsequence
    sequence s_stall;
        O_VALID && !I_READY && !I_STOP;
    endsequence
    a_reset_idle: assert property (disable iff (1'b0)
        !I_RST_N |=> !O_VALID && O_IDLE) else $error("not idle in reset");
    a_word_holds: assert property (s_stall
        |=> O_VALID && $stable(O_STREAM_ID)) else $error("stalled word lost");
    a_first_word: assert property (s_launch
        ##0 I_PORT_KIND == TSS_PORT_ETH |-> ##[2:3] O_VALID)
        else $error("first word late");
    a_launch_busy: assert property (s_launch
        |=> O_BUSY && !O_IDLE) else $error("start not taken");
    a_idle_quiet: assert property (O_IDLE && !I_START
        |=> O_IDLE && !O_VALID) else $error("output while idle");
    a_stop_idle: assert property (I_STOP && I_READY
        |-> ##[1:8] O_IDLE) else $error("stop not obeyed");
    a_id_range: assert property (O_VALID && !O_EMPTY_FRAME
        |-> O_STREAM_ID < I_NUM_STREAMS) else $error("stream id range");
    a_seq_order: assert property (take && seen
        && I_MODE == TSS_MODE_SEQ |-> O_STREAM_ID >= prev
        || O_STREAM_ID == '0) else $error("stream order broken");
    a_last_idle: assert property (take && O_LAST
        && I_MODE == TSS_MODE_SEQ && !I_REPEAT_FOREVER
        && I_REPEAT_COUNT == '0 |-> ##[1:LAST_WAIT] O_IDLE)
        else $error("no idle after last");
endmodule : tss_chk
bind tss_scheduler tss_chk #(.SID_W(SID_W), .CNT_W(CNT_W)) u_chk (
    .I_SYS_CLK(I_SYS_CLK), .I_RST_N(I_RST_N), .I_START(I_START),
    .I_STOP(I_STOP), .I_MODE(I_MODE), .I_PORT_KIND(I_PORT_KIND),
    .I_NUM_STREAMS(I_NUM_STREAMS), .I_REPEAT_FOREVER(I_REPEAT_FOREVER),
    .I_REPEAT_COUNT(I_REPEAT_COUNT), .I_READY(I_READY),
    .O_VALID(O_VALID), .O_STREAM_ID(O_STREAM_ID),
    .O_EMPTY_FRAME(O_EMPTY_FRAME), .O_LAST(O_LAST), .O_BUSY(O_BUSY),
    .O_IDLE(O_IDLE));
